/* logic/utt_pkg.sv */
package utt_pkg;
	// register location and layout
	localparam logic [11:0] TUNE_OFFSET      = 12'h06C;
	localparam int          WM_DIS_BIT       = 0;
	localparam int          RING_DIS_BIT     = 1;
	localparam logic [31:0] TUNE_RESET       = 32'h0000_0003;
	// early-start watermark levels per packet size, in bytes
	localparam logic [10:0] PKT_192          = 11'h0C0;
	localparam logic [10:0] PKT_256          = 11'h100;
	localparam logic [10:0] PKT_384          = 11'h180;
	localparam logic [10:0] PKT_512          = 11'h200;
	localparam logic [10:0] PKT_640          = 11'h280;
	localparam logic [10:0] PKT_1024         = 11'h400;
	localparam logic [10:0] WM_191           = 11'h0BF;
	localparam logic [10:0] WM_255           = 11'h0FF;
	localparam logic [10:0] WM_383           = 11'h17F;
	localparam logic [10:0] WM_511           = 11'h1FF;
	localparam logic [10:0] WM_639           = 11'h27F;
	localparam logic [10:0] WM_767           = 11'h2FF;

	// memory-space register access from the bus front end
	typedef struct packed {
		logic        sel;
		logic        wr;
		logic [11:0] addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} utt_req_t;

	// out-packet fetch progress
	typedef struct packed {
		logic        bulk_int;
		logic [10:0] pkt_size;
		logic [10:0] fetched;
	} utt_out_t;
endpackage

/* logic/utt_out_start.sv */
`timescale 1ns/100ps
`default_nettype none
// decides when an out packet may start on the wire
module utt_out_start (
	input  wire logic            clk_i,
	input  wire logic            rst_b_i,
	input  wire utt_pkg::utt_out_t out_i,
	input  wire logic            wm_en_i,
	output logic                 start_o
);
	import utt_pkg::*;

	logic [10:0] level;

	// watermark level one below the packet size for 192 to 640, 767 from 1024 up, else the size itself
	function automatic logic [10:0] wm_level(input logic [10:0] size);
		if (size == PKT_192) begin
			wm_level = WM_191;
		end else if (size == PKT_256) begin
			wm_level = WM_255;
		end else if (size == PKT_384) begin
			wm_level = WM_383;
		end else if (size == PKT_512) begin
			wm_level = WM_511;
		end else if (size == PKT_640) begin
			wm_level = WM_639;
		end else if (size >= PKT_1024) begin
			wm_level = WM_767;
		end else begin
			wm_level = size;
		end
	endfunction

	// early start on the watermark, else only once the whole packet is in
	always_comb begin
		level = wm_level(out_i.pkt_size);
		if (wm_en_i && out_i.bulk_int) begin
			start_o = (out_i.fetched >= level);
		end else begin
			start_o = (out_i.fetched >= out_i.pkt_size) && (out_i.pkt_size != 11'h000);
		end
	end

	wm_1024_a : assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(wm_en_i && out_i.bulk_int && out_i.pkt_size == PKT_1024 && out_i.fetched == WM_767)
		|-> start_o) else $error("no start at 767 of 1024");
	wm_early_a : assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(wm_en_i && out_i.bulk_int && out_i.fetched < wm_level(out_i.pkt_size))
		|-> !start_o) else $error("started below watermark");
	wm_off_a : assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(!wm_en_i && out_i.fetched < out_i.pkt_size) |-> !start_o)
		else $error("early start with watermark off");
endmodule
`default_nettype wire

/* logic/utt_tuning.sv */
`timescale 1ns/100ps
`default_nettype none
module utt_tuning (
	input  wire logic              SYS_CLK_I,
	input  wire logic              RST_B_I,
	input  wire utt_pkg::utt_req_t REQ_I,
	output logic [31:0]            RDATA_O,
	input  wire logic              TUNING_STRAP_PIN_I,
	input  wire logic              IN_PKT_DONE_I,
	input  wire logic              IN_PKT_PENDING_I,
	output logic                   IN_START_O,
	input  wire utt_pkg::utt_out_t OUT_I,
	output logic                   OUT_START_O,
	output logic                   RING_EN_O,
	output logic                   WM_EN_O
);
	import utt_pkg::*;

	logic [31:0] tune_reg;
	logic [31:0] tune_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [31:0] tune_view;
	logic        hit;

	// strap forces both disable bits high on read and in effect
	always_comb begin
		tune_view = tune_reg;
		if (TUNING_STRAP_PIN_I) begin
			tune_view[RING_DIS_BIT] = 1'b1;
			tune_view[WM_DIS_BIT]   = 1'b1;
		end
		RING_EN_O = !tune_view[RING_DIS_BIT];
		WM_EN_O   = !tune_view[WM_DIS_BIT];
	end

	// register write with byte enables, registered read data
	always_comb begin
		hit        = REQ_I.sel && (REQ_I.addr == TUNE_OFFSET);
		tune_next  = tune_reg;
		rdata_next = rdata_reg;
		if (hit && REQ_I.wr) begin
			for (int b = 0; b < 4; b++) begin
				if (REQ_I.be[b]) begin
					tune_next[b*8 +: 8] = REQ_I.wdata[b*8 +: 8];
				end
			end
		end else if (hit) begin
			rdata_next = tune_view;
		end else if (REQ_I.sel) begin
			rdata_next = 32'h0000_0000;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			tune_reg  <= TUNE_RESET;
			rdata_reg <= 32'h0000_0000;
		end else begin
			tune_reg  <= tune_next;
			rdata_reg <= rdata_next;
		end
	end

	assign RDATA_O = rdata_reg;

	// ring buffering lets the next in packet go as soon as one lands
	assign IN_START_O = IN_PKT_PENDING_I && (RING_EN_O ? 1'b1 : IN_PKT_DONE_I);

	utt_out_start utt_out_start_inst (
		.clk_i   (SYS_CLK_I),
		.rst_b_i (RST_B_I),
		.out_i   (OUT_I),
		.wm_en_i (WM_EN_O),
		.start_o (OUT_START_O)
	);

	strap_rbd_a : assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
		TUNING_STRAP_PIN_I |-> !RING_EN_O) else $error("ring on under strap");
	strap_wmd_a : assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
		TUNING_STRAP_PIN_I |-> !WM_EN_O) else $error("watermark on under strap");
	strap_read_a : assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
		(REQ_I.sel && !REQ_I.wr && REQ_I.addr == TUNE_OFFSET && TUNING_STRAP_PIN_I)
		|=> RDATA_O[1:0] == 2'h3) else $error("strap read not 1");
	write_back_a : assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
		(REQ_I.sel && REQ_I.wr && REQ_I.addr == TUNE_OFFSET && REQ_I.be == 4'hF)
		##1 (REQ_I.sel && !REQ_I.wr && REQ_I.addr == TUNE_OFFSET && !TUNING_STRAP_PIN_I)
		|=> RDATA_O == $past(REQ_I.wdata, 2)) else $error("readback mismatch");
	ring_ctl_a : assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
		(REQ_I.sel && REQ_I.wr && REQ_I.addr == TUNE_OFFSET && REQ_I.be[0]
		&& !TUNING_STRAP_PIN_I) |=> (RING_EN_O == !$past(REQ_I.wdata[1])
		|| TUNING_STRAP_PIN_I)) else $error("ring enable wrong");
	wm_ctl_a : assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
		(REQ_I.sel && REQ_I.wr && REQ_I.addr == TUNE_OFFSET && REQ_I.be[0]
		&& !TUNING_STRAP_PIN_I) |=> (WM_EN_O == !$past(REQ_I.wdata[0])
		|| TUNING_STRAP_PIN_I)) else $error("watermark enable wrong");
	ring_go_a : assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
		(RING_EN_O && IN_PKT_PENDING_I) |-> IN_START_O)
		else $error("ring start held back");
	ring_wait_a : assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
		(!RING_EN_O && !IN_PKT_DONE_I) |-> !IN_START_O)
		else $error("in started before previous done");
endmodule
`default_nettype wire

/* bench/utt_tuning_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module utt_tuning_bench;
	import utt_pkg::*;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	utt_req_t    req = '0;
	logic        strap = 1'b0;
	logic        done = 1'b0;
	logic        pend = 1'b0;
	utt_out_t    out = '0;
	logic [31:0] rdata;
	logic        in_start, out_start, ring_en, wm_en;
	int          n_fail = 0;
	int          tests_run = 0;
	int          cyc = 0;
	logic [31:0] v;
	logic [10:0] sz [6] = '{PKT_192, PKT_256, PKT_384, PKT_512, PKT_640, PKT_1024};
	logic [10:0] lv [6] = '{WM_191, WM_255, WM_383, WM_511, WM_639, WM_767};

	// clock and a cycle ceiling against hangs
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc > 3000) begin
			n_fail++;
			tally_and_finish();
		end
	end

	utt_tuning utt_tuning_inst (.SYS_CLK_I(clk), .RST_B_I(rst_b), .REQ_I(req), .RDATA_O(rdata),
		.TUNING_STRAP_PIN_I(strap), .IN_PKT_DONE_I(done), .IN_PKT_PENDING_I(pend),
		.IN_START_O(in_start), .OUT_I(out), .OUT_START_O(out_start), .RING_EN_O(ring_en),
		.WM_EN_O(wm_en));

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// write then read back to back, read data taken after the answer edge
	task automatic wr_rd(logic [31:0] d);
		@(posedge clk);
		req <= '{1'b1, 1'b1, TUNE_OFFSET, 4'hF, d};
		@(posedge clk);
		req <= '{1'b1, 1'b0, TUNE_OFFSET, 4'hF, 32'h0000_0000};
		@(posedge clk);
		req.sel <= 1'b0;
		#1;
		chk("b2b_read", d, rdata);
	endtask

	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// one register access, returning just after the answer edge so the caller can check read data
	task automatic acc(logic wr, logic [11:0] a, logic [31:0] d);
		@(posedge clk);
		req <= '{1'b1, wr, a, 4'hF, d};
		@(posedge clk);
		req.sel <= 1'b0;
		#1;
	endtask

	// start level: one below the packet for 192 to 640 bulk/interrupt with watermark on, 767 from 1024 up, else the size itself
	function automatic logic exp_out(utt_out_t o, logic wm);
		logic [10:0] l;
		l = o.pkt_size;
		if (wm && o.bulk_int) begin
			if (l >= PKT_1024) l = WM_767;
			else if (l inside {PKT_192, PKT_256, PKT_384, PKT_512, PKT_640}) l = l - 11'h001;
		end
		return o.fetched >= l;
	endfunction

	// in-start and out-start permission under the current mode
	task automatic paths(logic ring, logic wm);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			{pend, done} <= i[1:0];
			#1 chk("in_start", i[1] && (ring || i[0]), in_start);
		end
		for (int i = 0; i < 24; i++) begin
			@(posedge clk);
			if (i < 12) out <= '{1'b1, sz[i/2], lv[i/2] - 11'(i % 2 == 0)};
			else out <= '{1'($urandom), 11'($urandom_range(1024, 1)), 11'($urandom_range(1100, 0))};
			#1 chk("out_start", exp_out(out, wm), out_start);
		end
	endtask

	initial begin
		v = $urandom(63);
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		acc(1'b0, TUNE_OFFSET, 32'h0);
		chk("reset_value", TUNE_RESET, rdata);
		chk("ring_en", 32'h0, ring_en);
		chk("wm_en", 32'h0, wm_en);
		for (int m = 0; m < 4; m++) begin
			v = {30'h0, 2'(m)};
			acc(1'b1, TUNE_OFFSET, v);
			acc(1'b0, TUNE_OFFSET, 32'h0);
			chk("tune_read", v, rdata);
			chk("ring_en", !v[RING_DIS_BIT], ring_en);
			chk("wm_en", !v[WM_DIS_BIT], wm_en);
			paths(!v[RING_DIS_BIT], !v[WM_DIS_BIT]);
		end
		strap <= 1'b1;
		acc(1'b1, TUNE_OFFSET, 32'h0);
		acc(1'b0, TUNE_OFFSET, 32'h0);
		chk("strap_read", 32'h3, rdata);
		chk("strap_ring", 32'h0, ring_en);
		chk("strap_wm", 32'h0, wm_en);
		paths(1'b0, 1'b0);
		strap <= 1'b0;
		acc(1'b1, 12'h070, 32'h3);
		acc(1'b0, 12'h070, 32'h0);
		chk("unmapped_read", 32'h0, rdata);
		acc(1'b0, TUNE_OFFSET, 32'h0);
		chk("after_unmapped", 32'h0, rdata);
		wr_rd(32'h0000_0001);
		wr_rd(32'h0000_0002);
		tally_and_finish();
	end
endmodule
`default_nettype wire
